/* File: inc/uart_core_pkg.sv */
/*
 * shared constants, state enum and parity helper for the serial port core.
 * assumes: byte-addressed register port with 8-bit offsets, 32-bit data.
 */
`default_nettype none
package uart_core_pkg;
   // -----------------------------------------------------------------
   // register offsets
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] DATA_PORT_OFS = 8'h00;
   localparam logic [7:0] FLAG_OFS = 8'h18;
   localparam logic [7:0] INT_DIV_OFS = 8'h24;
   localparam logic [7:0] FRAC_DIV_OFS = 8'h28;
   localparam logic [7:0] LINE_CTL_OFS = 8'h2c;
   localparam logic [7:0] PORT_CTL_OFS = 8'h30;
   localparam logic [7:0] PIN_ALT_OFS = 8'h34;

   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int CTL_EN_BIT = 0;
   localparam int CTL_SIR_BIT = 1;
   localparam int CTL_TXE_BIT = 8;
   localparam int CTL_RXE_BIT = 9;
   localparam logic [9:0] CTL_RESET = 10'h300;
   localparam int LC_PEN_BIT = 1;
   localparam int LC_EPS_BIT = 2;
   localparam int LC_STP2_BIT = 3;
   localparam int LC_FEN_BIT = 4;
   localparam int LC_WLEN_LO = 5;
   localparam int LC_SPS_BIT = 7;
   localparam logic [29:0] WORK_RESET = 30'h0;
   localparam logic [15:0] INT_DIV_RESET = 16'h0;
   localparam logic [5:0] FRAC_DIV_RESET = 6'h0;
   localparam int FL_BUSY_BIT = 3;
   localparam int FL_RXFE_BIT = 4;
   localparam int FL_TXFF_BIT = 5;
   localparam int FL_RXFF_BIT = 6;
   localparam int FL_TXFE_BIT = 7;
   localparam int RX_FE_BIT = 8;
   localparam int RX_PE_BIT = 9;
   localparam int RX_BE_BIT = 10;
   localparam int RX_OE_BIT = 11;

   // -----------------------------------------------------------------
   // cycle counts, in oversample ticks
   // -----------------------------------------------------------------
   localparam logic [3:0] LAST_TICK = 4'hf;
   localparam logic [3:0] START_TICK = 4'h7;
   localparam logic [3:0] SIR_PULSE_TICKS = 4'h3;
   localparam logic [3:0] SIR_STRETCH = 4'hf;

   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP
   } frame_state_e;

   // parity over the active data bits; stick forces the inverse of even
   function automatic logic parity_bit(input logic [7:0] d,
         input logic [1:0] wlen, input logic even, input logic stick);
      logic [7:0] m;
      m = ~(8'he0 << wlen);
      if (stick) begin
         return ~even;
      end
      return even ? ^(d & m) : ~^(d & m);
   endfunction : parity_bit
endpackage : uart_core_pkg
`default_nettype wire

/* File: inc/fifo_if.sv */
/*
 * push/pop carrier between the port core and its byte stores.
 * assumes: one clock; owner drives strobes, store answers same cycle.
 */
`timescale 1ns/1ns
`default_nettype none
interface fifo_if #(parameter int W = 8) ();
   logic push;
   logic [W-1:0] wdata;
   logic pop;
   logic [W-1:0] rdata;
   logic empty;
   logic full;
   logic one_deep;
   modport owner(output push, wdata, pop, one_deep,
                 input rdata, empty, full);
   modport store(input push, wdata, pop, one_deep,
                 output rdata, empty, full);
endinterface : fifo_if
`default_nettype wire

/* File: design/byte_store.sv */
/*
 * flip-flop FIFO with a one-entry mode.
 * assumes: DEPTH is a power of two; pushes to full and pops of empty
 * are dropped.
 */
`timescale 1ns/1ns
`default_nettype none
module byte_store import uart_core_pkg::*; #(
   parameter int W = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   fifo_if.store f
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_ff [DEPTH];
   logic [PW-1:0] wr_ptr_ff;
   logic [PW-1:0] rd_ptr_ff;
   logic [PW:0] count_ff;
   logic do_push;
   logic do_pop;

   // disabled store behaves as a single holding register
   assign f.full = f.one_deep ? (count_ff != '0)
                              : (count_ff == (PW+1)'(DEPTH));
   assign f.empty = (count_ff == '0);
   assign f.rdata = mem_ff[rd_ptr_ff];
   assign do_push = f.push && !f.full;
   assign do_pop = f.pop && !f.empty;

   always_ff @(posedge clk_i) begin
      if (do_push) begin
         mem_ff[wr_ptr_ff] <= f.wdata;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_ptr_ff <= '0;
         rd_ptr_ff <= '0;
         count_ff <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_ff <= wr_ptr_ff + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_ff <= rd_ptr_ff + 1'b1;
         end
         count_ff <= count_ff + (PW+1)'(do_push) - (PW+1)'(do_pop);
      end
   end
endmodule : byte_store
`default_nettype wire

/* File: design/oversample_gen.sv */
/*
 * fractional divider making the 16x oversample tick.
 * assumes: integer part zero stops the tick.
 */
`timescale 1ns/1ns
`default_nettype none
module oversample_gen import uart_core_pkg::*; (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [15:0] div_int_i,
   input wire logic [5:0] div_frac_i,
   output logic oversample_tick_o
);
   logic [16:0] cnt_ff;
   logic [5:0] acc_ff;
   logic [6:0] sum;

   assign sum = {1'b0, acc_ff} + {1'b0, div_frac_i};

   // carry out of the fraction stretches one period by a cycle, so the
   // mean period equals the programmed divisor
   always_ff @(posedge clk_i) begin
      if (sys_rst_i || div_int_i == 16'h0) begin
         cnt_ff <= '0;
         acc_ff <= '0;
         oversample_tick_o <= 1'b0;
      end else if (cnt_ff <= 17'h1) begin
         oversample_tick_o <= 1'b1;
         acc_ff <= sum[5:0];
         cnt_ff <= {1'b0, div_int_i} + {16'h0, sum[6]};
      end else begin
         oversample_tick_o <= 1'b0;
         cnt_ff <= cnt_ff - 17'h1;
      end
   end
endmodule : oversample_gen
`default_nettype wire

/* File: design/async_serial_tx_rx_core.sv */
/*
 * asynchronous serial transmitter/receiver with register port,
 * fractional baud divider, byte FIFOs and optional infrared coding.
 * assumes: register strobes are one cycle, synchronous to clk_i; the
 * serial receive pin is asynchronous and is synchronised here.
 */
//
// Function
// - transmitter and receiver enable bits are set out of reset.
// - clearing the global enable lets the current character finish.
// - frame is start, data LSB first, optional parity, stop bits.
// - each received character carries overrun, parity, frame, break flags.
// - divisor is 16 integer bits plus 6 fraction bits.
// - divisor equals port clock over sixteen times baud rate.
// - oversample tick at 16x baud; bits last 16 ticks.
// - divisors and line control latch together on a line control write.
// - 16-entry byte transmit FIFO, 16-entry receive FIFO with status.
// - enabled port sends frames until the transmit FIFO runs empty.
// - busy while FIFO holds data or a character is still shifting.
// - start bit accepted only if still low at the eighth tick.
// - data bits sampled every 16 ticks, then parity checked.
// - low stop sample flags a framing error.
// - completed character goes into the receive FIFO with its flags.
// - infrared mode pulses the transmit pin and decodes receive pulses.
// - port 0 pins start as serial function, others as plain pins.
// - five to eight bits, even/odd/stick/no parity, one or two stops.
// - data read gives 12 bits; data write queues 8 bits.
// - FIFOs start disabled as one-entry holders; FIFO enable bit deepens.
`timescale 1ns/1ns
`default_nettype none
module async_serial_tx_rx_core import uart_core_pkg::*; #(
   parameter int PORT_INDEX = 0,
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic [31:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [31:0] reg_rdata_o,
   input wire logic serial_rx_pin_i,
   output logic serial_tx_pin_o,
   output logic serial_tx_oe_o,
   output logic serial_rx_sel_o
);
   // -----------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------
   // port 0 owns its pins from reset
   localparam logic PIN_ALT_RESET = 1'(PORT_INDEX == 0);

   logic [9:0] port_control_reg_ff;
   logic [15:0] integer_divisor_reg_ff;
   logic [5:0] fraction_divisor_reg_ff;
   logic [29:0] work_ff;
   logic alt_function_select_bit_ff;
   logic [31:0] rdata_ff;
   logic wr_data;
   logic rd_data;
   logic port_global_enable;
   logic tx_go;
   logic rx_go;
   logic sir_en;
   logic [1:0] wlen;
   logic [2:0] last_bit;
   logic busy;
   logic tick;

   fifo_if #(.W(8)) txf();
   fifo_if #(.W(12)) rxf();

   assign wr_data = reg_wr_i && (reg_addr_i == DATA_PORT_OFS);
   assign rd_data = reg_rd_i && (reg_addr_i == DATA_PORT_OFS);
   assign port_global_enable = port_control_reg_ff[CTL_EN_BIT];
   // new frames need enable; a running frame ignores it
   assign tx_go = port_global_enable && port_control_reg_ff[CTL_TXE_BIT];
   assign rx_go = port_global_enable && port_control_reg_ff[CTL_RXE_BIT];
   assign sir_en = port_control_reg_ff[CTL_SIR_BIT];
   assign wlen = work_ff[LC_WLEN_LO +: 2];
   // word length field picks five to eight bits
   assign last_bit = {1'b0, wlen} + 3'd4;

   // control resets with both direction enables set
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         port_control_reg_ff <= CTL_RESET;
      end else if (reg_wr_i && reg_addr_i == PORT_CTL_OFS) begin
         port_control_reg_ff <= reg_wdata_i[9:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         integer_divisor_reg_ff <= INT_DIV_RESET;
         fraction_divisor_reg_ff <= FRAC_DIV_RESET;
      end else begin
         if (reg_wr_i && reg_addr_i == INT_DIV_OFS) begin
            integer_divisor_reg_ff <= reg_wdata_i[15:0];
         end
         if (reg_wr_i && reg_addr_i == FRAC_DIV_OFS) begin
            fraction_divisor_reg_ff <= reg_wdata_i[5:0];
         end
      end
   end

   // working copy moves only on a line control write
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         work_ff <= WORK_RESET;
      end else if (reg_wr_i && reg_addr_i == LINE_CTL_OFS) begin
         work_ff <= {integer_divisor_reg_ff, fraction_divisor_reg_ff,
                     reg_wdata_i[7:0]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         alt_function_select_bit_ff <= PIN_ALT_RESET;
      end else if (reg_wr_i && reg_addr_i == PIN_ALT_OFS) begin
         alt_function_select_bit_ff <= reg_wdata_i[0];
      end
   end

   // data read returns byte plus four status flags
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rdata_ff <= 32'h0;
      end else if (reg_rd_i) begin
         rdata_ff <= 32'h0;
         case (reg_addr_i)
            DATA_PORT_OFS: rdata_ff[11:0] <= rxf.rdata;
            FLAG_OFS: begin
               rdata_ff[FL_BUSY_BIT] <= busy;
               rdata_ff[FL_RXFE_BIT] <= rxf.empty;
               rdata_ff[FL_TXFF_BIT] <= txf.full;
               rdata_ff[FL_RXFF_BIT] <= rxf.full;
               rdata_ff[FL_TXFE_BIT] <= txf.empty;
            end
            INT_DIV_OFS: rdata_ff[15:0] <= integer_divisor_reg_ff;
            FRAC_DIV_OFS: rdata_ff[5:0] <= fraction_divisor_reg_ff;
            LINE_CTL_OFS: rdata_ff[7:0] <= work_ff[7:0];
            PORT_CTL_OFS: rdata_ff[9:0] <= port_control_reg_ff;
            PIN_ALT_OFS: rdata_ff[0] <= alt_function_select_bit_ff;
            default: rdata_ff <= 32'h0;
         endcase
      end
   end
   assign reg_rdata_o = rdata_ff;

   // -----------------------------------------------------------------
   // tick source and stores
   // -----------------------------------------------------------------
   // divisor drives the tick period
   oversample_gen u_tick (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .div_int_i(work_ff[29:14]),
      .div_frac_i(work_ff[13:8]),
      .oversample_tick_o(tick)
   );

   // stores collapse to one entry until the enable bit is set
   assign txf.one_deep = !work_ff[LC_FEN_BIT];
   assign rxf.one_deep = !work_ff[LC_FEN_BIT];
   assign txf.push = wr_data;
   assign txf.wdata = reg_wdata_i[7:0];
   assign rxf.pop = rd_data;

   byte_store #(.W(8), .DEPTH(FIFO_DEPTH)) u_tx_store (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .f(txf.store)
   );
   byte_store #(.W(12), .DEPTH(FIFO_DEPTH)) u_rx_store (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .f(rxf.store)
   );

   // -----------------------------------------------------------------
   // transmitter
   // -----------------------------------------------------------------
   frame_state_e tx_state_ff;
   logic [3:0] tx_tick_ff;
   logic [2:0] tx_bit_ff;
   logic [7:0] tx_shift_ff;
   logic tx_par_ff;
   logic tx_stop2_ff;
   logic tx_line_ff;
   logic tx_pin_ff;

   // busy covers queued bytes and the shifter
   assign busy = !txf.empty || (tx_state_ff != ST_IDLE);

   // next byte leaves the store only when idle and enabled
   assign txf.pop = (tx_state_ff == ST_IDLE) && tx_go && !txf.empty;

   // start, data lsb first, parity, stop
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_state_ff <= ST_IDLE;
         tx_tick_ff <= 4'h0;
         tx_bit_ff <= 3'h0;
         tx_shift_ff <= 8'h0;
         tx_par_ff <= 1'b0;
         tx_stop2_ff <= 1'b0;
         tx_line_ff <= 1'b1;
      end else if (tx_state_ff == ST_IDLE) begin
         tx_line_ff <= 1'b1;
         tx_tick_ff <= 4'h0;
         if (txf.pop) begin
            tx_shift_ff <= txf.rdata;
            tx_par_ff <= parity_bit(txf.rdata, wlen,
               work_ff[LC_EPS_BIT], work_ff[LC_SPS_BIT]);
            tx_state_ff <= ST_START;
            tx_line_ff <= 1'b0;
         end
      end else if (tick) begin
         tx_tick_ff <= tx_tick_ff + 4'h1;
         if (tx_tick_ff == LAST_TICK) begin
            case (tx_state_ff)
               ST_START: begin
                  tx_state_ff <= ST_DATA;
                  tx_bit_ff <= 3'h0;
                  tx_line_ff <= tx_shift_ff[0];
               end
               ST_DATA: begin
                  tx_shift_ff <= tx_shift_ff >> 1;
                  if (tx_bit_ff == last_bit) begin
                     tx_stop2_ff <= work_ff[LC_STP2_BIT];
                     if (work_ff[LC_PEN_BIT]) begin
                        tx_state_ff <= ST_PARITY;
                        tx_line_ff <= tx_par_ff;
                     end else begin
                        tx_state_ff <= ST_STOP;
                        tx_line_ff <= 1'b1;
                     end
                  end else begin
                     tx_bit_ff <= tx_bit_ff + 3'h1;
                     tx_line_ff <= tx_shift_ff[1];
                  end
               end
               ST_PARITY: begin
                  tx_state_ff <= ST_STOP;
                  tx_line_ff <= 1'b1;
               end
               ST_STOP: begin
                  // busy holds through the last stop bit
                  if (tx_stop2_ff) begin
                     tx_stop2_ff <= 1'b0;
                  end else begin
                     tx_state_ff <= ST_IDLE;
                  end
               end
               default: tx_state_ff <= ST_IDLE;
            endcase
         end
      end
   end

   // infrared: zero becomes a 3/16 high pulse, one stays low
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         tx_pin_ff <= 1'b1;
      end else if (sir_en) begin
         tx_pin_ff <= !tx_line_ff && (tx_tick_ff < SIR_PULSE_TICKS);
      end else begin
         tx_pin_ff <= tx_line_ff;
      end
   end
   assign serial_tx_pin_o = tx_pin_ff;
   // pin driven only while the serial function owns it
   assign serial_tx_oe_o = alt_function_select_bit_ff;
   assign serial_rx_sel_o = alt_function_select_bit_ff;

   // -----------------------------------------------------------------
   // receiver
   // -----------------------------------------------------------------
   logic rx_meta_ff;
   logic rx_sync_ff;
   logic [3:0] sir_hold_ff;
   logic rx_line;
   frame_state_e rx_state_ff;
   logic [3:0] rx_tick_ff;
   logic [2:0] rx_bit_ff;
   logic [7:0] rx_shift_ff;
   logic rx_pe_ff;
   logic rx_zero_ff;
   logic rx_push_ff;
   logic [11:0] rx_word_ff;
   logic overrun_pend_ff;

   // two-flop synchroniser on the receive pin
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rx_meta_ff <= 1'b1;
         rx_sync_ff <= 1'b1;
      end else begin
         rx_meta_ff <= serial_rx_pin_i;
         rx_sync_ff <= rx_meta_ff;
      end
   end

   // a short low pulse marks a zero for one bit time
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         sir_hold_ff <= 4'h0;
      end else if (!rx_sync_ff) begin
         sir_hold_ff <= SIR_STRETCH;
      end else if (tick && sir_hold_ff != 4'h0) begin
         sir_hold_ff <= sir_hold_ff - 4'h1;
      end
   end
   assign rx_line = sir_en ? (rx_sync_ff && sir_hold_ff == 4'h0)
                           : rx_sync_ff;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         rx_state_ff <= ST_IDLE;
         rx_tick_ff <= 4'h0;
         rx_bit_ff <= 3'h0;
         rx_shift_ff <= 8'h0;
         rx_pe_ff <= 1'b0;
         rx_zero_ff <= 1'b0;
         rx_push_ff <= 1'b0;
         rx_word_ff <= 12'h0;
      end else begin
         rx_push_ff <= 1'b0;
         case (rx_state_ff)
            ST_IDLE: begin
               rx_tick_ff <= 4'h0;
               if (rx_go && !rx_line) begin
                  rx_state_ff <= ST_START;
               end
            end
            ST_START: if (tick) begin
               rx_tick_ff <= rx_tick_ff + 4'h1;
               // line must still be low at the eighth tick
               if (rx_tick_ff == START_TICK) begin
                  rx_tick_ff <= 4'h0;
                  rx_bit_ff <= 3'h0;
                  rx_shift_ff <= 8'h0;
                  rx_pe_ff <= 1'b0;
                  rx_zero_ff <= 1'b1;
                  rx_state_ff <= rx_line ? ST_IDLE : ST_DATA;
               end
            end
            ST_DATA: if (tick) begin
               rx_tick_ff <= rx_tick_ff + 4'h1;
               if (rx_tick_ff == LAST_TICK) begin
                  rx_shift_ff[rx_bit_ff] <= rx_line;
                  rx_zero_ff <= rx_zero_ff && !rx_line;
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == last_bit) begin
                     rx_state_ff <= work_ff[LC_PEN_BIT] ? ST_PARITY
                                                        : ST_STOP;
                  end
               end
            end
            ST_PARITY: if (tick) begin
               rx_tick_ff <= rx_tick_ff + 4'h1;
               if (rx_tick_ff == LAST_TICK) begin
                  rx_pe_ff <= rx_line != parity_bit(rx_shift_ff, wlen,
                     work_ff[LC_EPS_BIT], work_ff[LC_SPS_BIT]);
                  rx_zero_ff <= rx_zero_ff && !rx_line;
                  rx_state_ff <= ST_STOP;
               end
            end
            ST_STOP: if (tick) begin
               rx_tick_ff <= rx_tick_ff + 4'h1;
               if (rx_tick_ff == LAST_TICK) begin
                  rx_state_ff <= ST_IDLE;
                  rx_push_ff <= 1'b1;
                  rx_word_ff[7:0] <= rx_shift_ff;
                  // low stop sample is a framing error
                  rx_word_ff[RX_FE_BIT] <= !rx_line;
                  rx_word_ff[RX_PE_BIT] <= rx_pe_ff;
                  // low through the stop position is a break
                  rx_word_ff[RX_BE_BIT] <= rx_zero_ff && !rx_line;
                  rx_word_ff[RX_OE_BIT] <= overrun_pend_ff;
               end
            end
            default: rx_state_ff <= ST_IDLE;
         endcase
      end
   end

   // finished character and its flags enter the store
   assign rxf.push = rx_push_ff;
   assign rxf.wdata = rx_word_ff;

   // a character lost to a full store flags the next one stored
   // a new loss in the same cycle wins over the clear
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         overrun_pend_ff <= 1'b0;
      end else if (rx_push_ff && rxf.full) begin
         overrun_pend_ff <= 1'b1;
      end else if (rx_push_ff) begin
         overrun_pend_ff <= 1'b0;
      end
   end
endmodule : async_serial_tx_rx_core
`default_nettype wire

/* File: testbench/uart_core_sva.sv */
/* port checker for the serial core, bound to every core instance.
   assumes at least one clock a tick and 8-bit register offsets. */
`timescale 1ns/1ns
`default_nettype none
module uart_core_chk import uart_core_pkg::*; #(
   parameter int PORT_INDEX = 0
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [31:0] reg_rdata_o,
   input wire logic serial_tx_pin_o,
   input wire logic serial_tx_oe_o,
   input wire logic serial_rx_sel_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   chk_ctl_reset: assert property (
      ($past(sys_rst_i, 2) && reg_rd_i && reg_addr_i == PORT_CTL_OFS)
      |=> reg_rdata_o == 32'h300) else $error("control reset value");
   chk_unmapped_zero: assert property (
      (reg_rd_i && reg_addr_i == 8'h04) |=> reg_rdata_o == 32'h0)
      else $error("unmapped read");
   chk_rdata_hold: assert property (
      !$past(reg_rd_i) |-> $stable(reg_rdata_o)) else $error("data moved");
   chk_busy_set: assert property (
      (reg_wr_i && reg_addr_i == DATA_PORT_OFS) ##1
      (reg_rd_i && reg_addr_i == FLAG_OFS) |=> reg_rdata_o[FL_BUSY_BIT])
      else $error("busy not set");
   chk_start_len: assert property (
      $fell(serial_tx_pin_o) |=> !serial_tx_pin_o [*7])
      else $error("low bit too short");
   chk_pulse_len: assert property (
      $rose(serial_tx_pin_o) |=> serial_tx_pin_o [*2])
      else $error("high level too short");
   chk_sel_match: assert property (
      ($changed(serial_tx_oe_o) || $changed(serial_rx_sel_o))
      |-> $past(reg_wr_i && reg_addr_i == PIN_ALT_OFS)
      && serial_rx_sel_o == serial_tx_oe_o)
      else $error("pin owner moved without a write");
   chk_own_reset: assert property (
      $past(sys_rst_i) |-> serial_tx_oe_o == (PORT_INDEX == 0))
      else $error("pin owner after reset");
   cover property (reg_rd_i && reg_addr_i == DATA_PORT_OFS);
   cover property ($fell(serial_tx_pin_o));
   cover property (reg_wr_i && reg_addr_i == LINE_CTL_OFS);
endmodule : uart_core_chk
bind async_serial_tx_rx_core uart_core_chk #(.PORT_INDEX(PORT_INDEX))
   chk (.*);
`default_nettype wire

/* File: testbench/serial_peer.sv */
/* remote serial device: frames bytes onto rx and decodes tx.
   assumes sixteen clocks a bit, 8 data bits, no parity. */
`timescale 1ns/1ns
`default_nettype none
module serial_peer (
   input wire logic clk_i,
   input wire logic tx_i,
   output logic rx_o,
   output logic got_o,
   output logic [7:0] byte_o
);
   initial rx_o = 1'b1;
   initial got_o = 1'b0;
   // the line is driven high from the start and after each frame, so it rests high between frames
   task automatic send(input logic [7:0] d, input logic stop);
      logic [9:0] f;
      f = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_o <= f[i];
         repeat (16) @(posedge clk_i);
      end
      rx_o <= 1'b1;
   endtask : send
   // sample mid-bit; a pulse on got_o only for a high stop
   always begin
      @(negedge tx_i);
      repeat (8) @(posedge clk_i);
      repeat (8) begin
         repeat (16) @(posedge clk_i);
         byte_o <= {tx_i, byte_o[7:1]};
      end
      repeat (16) @(posedge clk_i);
      got_o <= tx_i;
      @(posedge clk_i);
      got_o <= 1'b0;
   end
endmodule : serial_peer
`default_nettype wire

/* File: testbench/testbench.sv */
/* bench: register traffic and a remote serial peer around the core.
   assumes the checker binds itself to the core. */
`timescale 1ns/1ns
`default_nettype none
module testbench import uart_core_pkg::*;;
   localparam logic [1:0] W = 2'b10;
   localparam logic [1:0] R = 2'b01;
   localparam logic [1:0] I = 2'b00;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [7:0] reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0;
   logic [31:0] reg_rdata_o;
   logic serial_rx_pin_i, serial_tx_pin_o, serial_tx_oe_o, serial_rx_sel_o;
   logic rd_q = 1'b0;
   logic got;
   logic [7:0] gb, b;
   logic [63:0] e;
   logic [63:0] rq[$];
   logic [7:0] bq[$];
   int failures = 0;
   int n_tests = 0;
   always #2 clk_i = ~clk_i;
   async_serial_tx_rx_core uut (.*);
   serial_peer peer (.clk_i(clk_i), .tx_i(serial_tx_pin_o),
      .rx_o(serial_rx_pin_i), .got_o(got), .byte_o(gb));
   // a read notes {mask, value}; strobes stay up until the next call
   task automatic bus(input logic [1:0] o, input logic [7:0] ad,
         input logic [31:0] v, input logic [31:0] m = 32'hffffffff);
      {reg_wr_i, reg_rd_i} <= o;
      reg_addr_i <= ad;
      reg_wdata_i <= v;
      if (o[0]) begin
         rq.push_back({m, v});
      end
      @(posedge clk_i);
   endtask : bus
   task automatic idle(input int n);
      repeat (n) bus(I, 8'h00, 32'h0);
   endtask : idle
   task automatic cmp(input logic [31:0] g, input logic [31:0] x);
      n_tests++;
      if (g !== x) begin
         failures++;
         $display("unexpected at %0t: got %h want %h", $time, g, x);
      end
   endtask : cmp
   task automatic cmp_byte(input logic [7:0] g, input logic [7:0] x);
      cmp({24'h0, g}, {24'h0, x});
   endtask : cmp_byte
   task automatic complete_run;
      failures += rq.size() + bq.size();
      $display("comparisons %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   always @(posedge clk_i) begin
      if (rd_q) begin
         e = rq.pop_front();
         cmp(reg_rdata_o & e[63:32], e[31:0] & e[63:32]);
      end
      if (got) cmp_byte(gb, bq.pop_front());
      rd_q <= reg_rd_i;
   end
   initial begin
      void'($urandom(34));
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      bus(R, PORT_CTL_OFS, 32'h300);
      bus(R, 8'h04, 32'h0);
      bus(R, PIN_ALT_OFS, 32'h1);
      bus(W, PIN_ALT_OFS, 32'h0);
      bus(R, PIN_ALT_OFS, 32'h0);
      bus(W, PIN_ALT_OFS, 32'h1);
      bus(W, INT_DIV_OFS, 32'hffffffff);
      bus(W, FRAC_DIV_OFS, 32'hffffffff);
      bus(R, INT_DIV_OFS, 32'hffff);
      bus(R, FRAC_DIV_OFS, 32'h3f);
      // divisor 1.0: one tick a clock, sixteen clocks a bit
      bus(W, FRAC_DIV_OFS, 32'h0);
      bus(W, INT_DIV_OFS, 32'h1);
      bus(W, LINE_CTL_OFS, 32'h70);
      bus(W, PORT_CTL_OFS, 32'h301);
      repeat (2) begin
         b = 8'($urandom);
         bq.push_back(b);
         bus(W, DATA_PORT_OFS, {24'h0, b});
      end
      bus(R, FLAG_OFS, 32'h8, 32'h8);
      idle(400);
      bus(R, FLAG_OFS, 32'h90);
      idle(1);
      b = 8'($urandom) | 8'h01;
      peer.send(b, 1'b1);
      idle(20);
      bus(R, DATA_PORT_OFS, {24'h0, b}, 32'hfff);
      idle(1);
      peer.send(b, 1'b0);
      idle(20);
      bus(R, DATA_PORT_OFS, {24'h1, b}, 32'hfff);
      idle(1);
      peer.send(8'h00, 1'b0);
      idle(20);
      bus(R, DATA_PORT_OFS, 32'h500, 32'hfff);
      b = 8'($urandom);
      bq.push_back(b);
      bus(W, DATA_PORT_OFS, {24'h0, b});
      idle(40);
      bus(W, PORT_CTL_OFS, 32'h300);
      idle(200);
      bus(W, LINE_CTL_OFS, 32'h76);
      bus(W, PORT_CTL_OFS, 32'h301);
      idle(1);
      b = 8'($urandom);
      peer.send(b, 1'b1);
      idle(40);
      // even parity: the peer's high stop lands in the parity slot
      bus(R, DATA_PORT_OFS, {22'h0, ~^b, 1'b0, b}, 32'hfff);
      bus(W, PORT_CTL_OFS, 32'h300);
      bus(W, LINE_CTL_OFS, 32'h60);
      bus(W, PORT_CTL_OFS, 32'h301);
      idle(1);
      peer.send(8'h5a, 1'b1);
      idle(1);
      peer.send(8'ha5, 1'b1);
      idle(40);
      // one-deep store keeps the first byte and drops the second
      bus(R, DATA_PORT_OFS, 32'h5a, 32'hfff);
      idle(1);
      peer.send(8'h3c, 1'b1);
      idle(40);
      bus(R, DATA_PORT_OFS, 32'h83c, 32'hfff);
      idle(2);
      complete_run();
   end
   initial begin
      repeat (3000) @(posedge clk_i);
      failures++;
      complete_run();
   end
endmodule : testbench
`default_nettype wire
